// file: dv/reis_host.sv
// Host model: drives the register strobe port and collects read data.
`timescale 1ns/1ps
module reis_host (
	input  wire logic           clk,
	input  wire logic [7:0]     rdata,
	output reis_pkg::reis_req_t req
);
	initial req = '0;
	// idle writes
	// The radio side is kept quiet by the bench while configuration is written.
	task automatic wr(input logic [10:0] a, input logic [7:0] d);
		@(posedge clk) req <= '{1'b1, 1'b0, a, d};
		@(posedge clk) req <= '{1'b0, 1'b0, ~a, ~d};
	endtask
	// Read data is registered on the strobe edge, so it is taken just after it.
	task automatic rd(input logic [10:0] a, output logic [7:0] d);
		@(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk) req <= '{1'b0, 1'b0, ~a, 8'hA5};
		#1 d = rdata;
	endtask
endmodule

// file: dv/reis_properties.sv
// Port checker for the event collector.
`timescale 1ns/1ps
module reis_properties (
	input wire logic                   clk,
	input wire logic                   resetn,
	input wire reis_pkg::reis_events_t ev,
	input wire reis_pkg::reis_req_t    req,
	input wire logic [7:0]             rdata,
	input wire logic                   line_a,
	input wire logic                   line_b,
	input wire logic                   pending_summary_flag,
	input wire logic                   channel_clear_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// A captured event must read back set on a read soon after.
	property p_set(c, a, b);
		c ##[2:4] (req.rd && req.addr == a) |=> rdata[b];
	endproperty
	AST_SENT: assert property (p_set(ev.frame_sent && ev.standard_mode, 11'h3CC, 4))
		else $error("frame sent not captured");
	AST_RCVD: assert property (p_set(ev.frame_good && ev.standard_mode, 11'h3CC, 3))
		else $error("frame received not captured");
	AST_DSENT: assert property (p_set(ev.delimiter_sent && ev.standard_mode, 11'h3CC, 2))
		else $error("delimiter sent not captured");
	AST_DFOUND: assert property (p_set(ev.delimiter_found && ev.receive_state, 11'h3CC, 1))
		else $error("delimiter found not captured");
	AST_CHECK: assert property (p_set(ev.channel_done, 11'h3CC, 0))
		else $error("channel check not captured");
	AST_SUPPLY: assert property (p_set(ev.supply_alarm, 11'h3CB, 5))
		else $error("supply alarm not captured");
	AST_CMD: assert property (p_set($rose(ev.command_accept), 11'h3CB, 3))
		else $error("command accept not captured");
	AST_TIMER: assert property (p_set(ev.timer_zero, 11'h3CB, 2))
		else $error("timer expiry not captured");
	AST_READY: assert property (p_set($rose(ev.host_access), 11'h3CB, 1))
		else $error("access ready not captured");
	AST_CLEAR_FLAG: assert property (ev.channel_done |=> channel_clear_flag == $past(ev.channel_clear))
		else $error("channel clear flag not loaded");
	AST_PENDING: assert property (pending_summary_flag == (line_a || line_b))
		else $error("pending summary differs from lines");
	AST_RESERVED: assert property (req.rd && req.addr == 11'h3CB |=> rdata[0] == 1'b0 && rdata[7:6] == 2'h0)
		else $error("reserved source bits read nonzero");
	AST_W1C: assert property ((req.wr && req.addr == 11'h3CC && req.wdata == 8'hFF && ev == '0)
		##1 (ev == '0) [*3] ##1 (req.rd && req.addr == 11'h3CC) |=> rdata == 8'h00)
		else $error("source high byte not cleared");
	// Main scenarios are reached.
	cover property (req.rd && req.addr == 11'h3CB);
	cover property (line_a && line_b);
	cover property (ev.sleep_exit);
endmodule

// file: dv/reis_tb_top.sv
// Testbench of the event collector: registers, event capture and lines.
`timescale 1ns/1ps
module reis_tb_top;
	logic                   clk;
	logic                   resetn;
	reis_pkg::reis_events_t ev;
	reis_pkg::reis_req_t    req;
	logic [7:0]             rdata;
	logic                   line_a;
	logic                   line_b;
	logic                   pending_summary_flag;
	logic                   channel_clear_flag;
	int                     miscompares;
	int                     num_checks;
	int                     cycles;
	reis_top dut_u (.clk, .resetn, .ev, .req, .rdata, .line_a, .line_b,
		.pending_summary_flag, .channel_clear_flag);
	reis_host host_u (.clk, .rdata, .req);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Cut a hang short.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			wrap_up();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("ERROR %0t got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask
	task automatic rd_word(input logic [10:0] a, output logic [15:0] w);
		host_u.rd(a, w[7:0]);
		host_u.rd(a + 11'h1, w[15:8]);
	endtask
	task automatic wr_word(input logic [10:0] a, input logic [15:0] w);
		host_u.wr(a, w[7:0]);
		host_u.wr(a + 11'h1, w[15:8]);
	endtask
	// One-cycle event on the radio side.
	task automatic pulse(input reis_pkg::reis_events_t v);
		@(posedge clk) ev <= v;
		@(posedge clk) ev <= '0;
	endtask
	// Reset values, and an unmapped place that must read zero.
	task automatic t_reset();
		logic [15:0] w;
		rd_word(11'h3C7, w);
		chk(w, 16'h0002);
		rd_word(11'h3C9, w);
		chk(w, 16'h0002);
		host_u.wr(11'h3CD, 8'hFF);
		rd_word(11'h3CC, w);
		chk(w, 16'h0000);
	endtask
	// Every source in turn: capture, both lines, zero-write keeps, one-write clears.
	task automatic t_events();
		int          kv[10] = '{11, 10, 9, 8, 7, 5, 4, 3, 2, 0};
		int          bv[10] = '{12, 11, 10, 9, 8, 5, 3, 2, 1, 4};
		logic [15:0] w;
		logic [15:0] m;
		for (int i = 0; i < 10; i++) begin
			m = 16'h1 << bv[i];
			pulse(14'h3040 | (14'h1 << kv[i]));
			rd_word(11'h3CB, w);
			chk(w, m);
			wr_word(11'h3C7, m);
			wr_word(11'h3C9, m);
			wr_word(11'h3CB, ~m);
			// Lines launch on the write edge, so look at them half a cycle later.
			@(negedge clk);
			chk({line_a, line_b, pending_summary_flag}, 16'h7);
			wr_word(11'h3CB, 16'hFFFF);
			@(negedge clk);
			chk({line_a, line_b, pending_summary_flag}, 16'h0);
			rd_word(11'h3CB, w);
			chk(w, 16'h0000);
		end
		chk(channel_clear_flag, 16'h1);
	endtask
	// Mode gating: no capture outside the required mode or state.
	task automatic t_gating();
		logic [15:0] w;
		pulse(14'h0E00);
		pulse(14'h2100);
		rd_word(11'h3CB, w);
		chk(w, 16'h0000);
	endtask
	// Leaving sleep sets the access-ready enable in both masks.
	task automatic t_sleep();
		logic [15:0] w;
		wr_word(11'h3C7, 16'h0000);
		wr_word(11'h3C9, 16'h0000);
		pulse(14'h0002);
		rd_word(11'h3C7, w);
		chk(w, 16'h0002);
		rd_word(11'h3C9, w);
		chk(w, 16'h0002);
	endtask
	task automatic wrap_up();
		if (miscompares == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		resetn = 1'b0;
		ev = '0;
		miscompares = 0;
		num_checks = 0;
		cycles = 0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		t_reset();
		t_events();
		t_gating();
		t_sleep();
		wrap_up();
	end
endmodule
bind reis_top reis_properties chk_u (.clk, .resetn, .ev, .req, .rdata, .line_a, .line_b,
	.pending_summary_flag, .channel_clear_flag);

// file: src/reis_edge.sv
// Rising edge detector for a level flag.
`timescale 1ns/1ps
module reis_edge (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic level,
	output logic      rise
);
	// Previous value of the level.
	logic last;

	// Hold the level one cycle so a change can be seen.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			last <= 1'b0;
		end else begin
			last <= level;
		end
	end

	// A pulse in the cycle the level goes high.
	assign rise = level & ~last;
endmodule

// file: src/reis_pkg.sv
// Package with register map, field positions and carrier types of the radio event sources.
package reis_pkg;

	// Register addresses on the internal 11-bit register port.
	localparam logic [10:0] ADDR_LINE_A_MASK_LOW   = 11'h3C7;
	localparam logic [10:0] ADDR_LINE_A_MASK_HIGH  = 11'h3C8;
	localparam logic [10:0] ADDR_LINE_B_MASK_LOW   = 11'h3C9;
	localparam logic [10:0] ADDR_LINE_B_MASK_HIGH  = 11'h3CA;
	localparam logic [10:0] ADDR_EVENT_SOURCE_LOW  = 11'h3CB;
	localparam logic [10:0] ADDR_EVENT_SOURCE_HIGH = 11'h3CC;

	// Bit positions in the 16-bit source word (high byte is bits 15:8).
	localparam int BIT_ACCESS_READY   = 1;
	localparam int BIT_TIMER_EXPIRY   = 2;
	localparam int BIT_COMMAND_ACCEPT = 3;
	localparam int BIT_POWERON        = 4;
	localparam int BIT_SUPPLY_LOW     = 5;
	localparam int BIT_CHANNEL_DONE   = 8;
	localparam int BIT_DELIM_FOUND    = 9;
	localparam int BIT_DELIM_SENT     = 10;
	localparam int BIT_FRAME_RECEIVED = 11;
	localparam int BIT_FRAME_SENT     = 12;

	// Implemented bits; the others are reserved and read as zero.
	localparam logic [15:0] IMPL_MASK = 16'h1F3E;

	// Reset values of masks and sources.
	localparam logic [15:0] MASK_RESET   = 16'h0002;
	localparam logic [15:0] SOURCE_RESET = 16'h0000;

	// Raw event inputs from the rest of the radio, all levels or pulses.
	typedef struct packed {
		logic standard_mode;    // Standard packet mode active.
		logic receive_state;    // Radio is in its receive state.
		logic frame_sent;       // Pulse: frame in send buffer finished.
		logic frame_good;       // Pulse: frame with good FCS stored.
		logic delimiter_sent;   // Pulse: start delimiter transmitted.
		logic delimiter_found;  // Pulse: start delimiter detected.
		logic channel_done;     // Pulse: clear-channel measurement done.
		logic channel_clear;    // Result of the measurement.
		logic supply_alarm;     // Pulse: battery monitor alarm.
		logic command_accept;   // Level: controller takes commands.
		logic timer_zero;       // Pulse: wake timer reached zero.
		logic host_access;      // Level: ready for serial access.
		logic sleep_exit;       // Pulse: device just left sleep.
		logic poweron;          // Pulse: power-on reset seen.
	} reis_events_t;

	// Register port request.
	typedef struct packed {
		logic        wr;    // Write strobe.
		logic        rd;    // Read strobe.
		logic [10:0] addr;  // Register address.
		logic [7:0]  wdata; // Write data.
	} reis_req_t;

endpackage

// file: src/reis_regs.sv
// Register decode and read multiplexer for masks and sources.
`timescale 1ns/1ps
module reis_regs (
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire reis_pkg::reis_req_t req,
	input  wire logic [15:0]       mask_a,
	input  wire logic [15:0]       mask_b,
	input  wire logic [15:0]       source,
	output logic [7:0]             rdata,
	output logic [5:0]             wsel
);
	// One select per register, in table order.
	logic [5:0] hit;
	logic [7:0] next_rdata;

	assign hit[0] = req.addr == reis_pkg::ADDR_LINE_A_MASK_LOW;
	assign hit[1] = req.addr == reis_pkg::ADDR_LINE_A_MASK_HIGH;
	assign hit[2] = req.addr == reis_pkg::ADDR_LINE_B_MASK_LOW;
	assign hit[3] = req.addr == reis_pkg::ADDR_LINE_B_MASK_HIGH;
	assign hit[4] = req.addr == reis_pkg::ADDR_EVENT_SOURCE_LOW;
	assign hit[5] = req.addr == reis_pkg::ADDR_EVENT_SOURCE_HIGH;
	assign wsel = req.wr ? hit : 6'h00;

	// Unmapped addresses read as zero.
	assign next_rdata = ({8{hit[0]}} & mask_a[7:0]) | ({8{hit[1]}} & mask_a[15:8])
		| ({8{hit[2]}} & mask_b[7:0]) | ({8{hit[3]}} & mask_b[15:8])
		| ({8{hit[4]}} & source[7:0]) | ({8{hit[5]}} & source[15:8]);

	// Read data is registered and holds until the next read.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= 8'h00;
		end else if (req.rd) begin
			rdata <= next_rdata;
		end
	end
endmodule

// file: src/reis_top.sv
// Event source collector with two maskable interrupt lines.
// Notes on behaviour
// R1 - Frame sent sets event in standard mode.
// R2 - Good-FCS stored frame sets received event, standard mode.
// R3 - Delimiter transmitted sets event, standard mode.
// R4 - Delimiter found in receive state, any mode.
// R5 - Channel check completion sets its event.
// R6 - Channel clear flag valid by event.
// R7 - Battery alarm sets supply low event.
// R8 - Host must configure battery monitor first.
// R9 - Command accept flag rising sets event.
// R10 - Wake timer reaching zero sets event.
// R11 - Host programs timer before enabling event.
// R12 - Timer event works active or woken.
// R13 - Access ready event raised after wake.
// R14 - Access flag rising sets ready event.
// R15 - Sleep exit sets access enable bits.
// R16 - Ready event for any wake cause.
// R17 - Host configures preferably while idle.
// R18 - Controller-owned registers written only idle.
// R19 - Line A mask at 0x3C7/0x3C8.
// R20 - Line B mask at 0x3C9/0x3CA.
// R21 - Source flags at 0x3CB/0x3CC.
// R22 - Write one clears; zero keeps.
// R23 - High source byte bit placement.
// R24 - Low source byte bit placement.
// R25 - Pending summary when either line high.
// R26 - Line high when enabled source set.
`timescale 1ns/1ps
module reis_top (
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire reis_pkg::reis_events_t ev,
	input  wire reis_pkg::reis_req_t    req,
	output logic [7:0]                  rdata,
	output logic                        line_a,
	output logic                        line_b,
	output logic                        pending_summary_flag,
	output logic                        channel_clear_flag
);
	// Mask and source state.
	logic [15:0] mask_a;
	logic [15:0] mask_b;
	logic [15:0] source;
	logic [15:0] next_source;
	logic [15:0] set_vec;
	logic [15:0] clr_vec;
	logic [15:0] next_mask_a;
	logic [15:0] next_mask_b;
	logic [5:0]  wsel;
	logic        accept_rise;
	logic        access_rise;
	logic        next_line_a;
	logic        next_line_b;

	// Edge detectors for the two status flags.
	// R9 - command accept edge
	reis_edge u_accept (
		.clk    (clk),
		.resetn (resetn),
		.level  (ev.command_accept),
		.rise   (accept_rise)
	);

	// R14 - host access edge
	reis_edge u_access (
		.clk    (clk),
		.resetn (resetn),
		.level  (ev.host_access),
		.rise   (access_rise)
	);

	// Register decode and readback.
	// R19 - register decode
	reis_regs u_regs (
		.clk    (clk),
		.resetn (resetn),
		.req    (req),
		.mask_a (mask_a),
		.mask_b (mask_b),
		.source (source),
		.rdata  (rdata),
		.wsel   (wsel)
	);

	// Event set vector, one term per source bit.
	always_comb begin
		set_vec = 16'h0000;
		// R1 - frame sent
		set_vec[reis_pkg::BIT_FRAME_SENT] = ev.standard_mode & ev.frame_sent;
		// R2 - good frame received
		set_vec[reis_pkg::BIT_FRAME_RECEIVED] = ev.standard_mode & ev.frame_good;
		// R3 - delimiter sent
		set_vec[reis_pkg::BIT_DELIM_SENT] = ev.standard_mode & ev.delimiter_sent;
		// R4 - delimiter found
		set_vec[reis_pkg::BIT_DELIM_FOUND] = ev.receive_state & ev.delimiter_found;
		// R5 - channel check done
		set_vec[reis_pkg::BIT_CHANNEL_DONE] = ev.channel_done;
		// R7 - supply alarm
		set_vec[reis_pkg::BIT_SUPPLY_LOW] = ev.supply_alarm;
		// R9 - command accept rise
		set_vec[reis_pkg::BIT_COMMAND_ACCEPT] = accept_rise;
		// R10 - timer zero, R12 in any state
		set_vec[reis_pkg::BIT_TIMER_EXPIRY] = ev.timer_zero;
		// R13 - ready after wake, R16 any cause
		set_vec[reis_pkg::BIT_ACCESS_READY] = access_rise;
		set_vec[reis_pkg::BIT_POWERON] = ev.poweron;
	end

	// R22 - write one clears
	assign clr_vec = {wsel[5] ? req.wdata : 8'h00, wsel[4] ? req.wdata : 8'h00};
	// A set in the same cycle as its clear wins, so no event is lost.
	// R23 - reserved bits masked, R24 likewise
	assign next_source = ((source & ~clr_vec) | set_vec) & reis_pkg::IMPL_MASK;

	// Mask writes; sleep exit forces the access ready enable on the same edge, over any write.
	// R20 - line B mask writes
	assign next_mask_a = {wsel[1] ? req.wdata : mask_a[15:8], wsel[0] ? req.wdata : mask_a[7:0]};
	assign next_mask_b = {wsel[3] ? req.wdata : mask_b[15:8], wsel[2] ? req.wdata : mask_b[7:0]};

	// R26 - line levels
	assign next_line_a = |(next_source & next_mask_a);
	assign next_line_b = |(next_source & next_mask_b);

	// Source and mask registers.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			source <= reis_pkg::SOURCE_RESET;
			mask_a <= reis_pkg::MASK_RESET;
			mask_b <= reis_pkg::MASK_RESET;
		end else begin
			// R21 - source update
			source <= next_source;
			if (ev.sleep_exit) begin
				// R15 - force ready enables
				mask_a <= next_mask_a | reis_pkg::MASK_RESET;
				mask_b <= next_mask_b | reis_pkg::MASK_RESET;
			end else begin
				mask_a <= next_mask_a;
				mask_b <= next_mask_b;
			end
		end
	end

	// Output lines, summary and clear flag, all registered.
	// Lines follow the new source in the same edge, so they match readback.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			line_a               <= 1'b0;
			line_b               <= 1'b0;
			pending_summary_flag <= 1'b0;
			channel_clear_flag   <= 1'b0;
		end else begin
			line_a <= next_line_a;
			line_b <= next_line_b;
			// R25 - summary of both lines
			pending_summary_flag <= next_line_a | next_line_b;
			// R6 - result valid with event
			if (ev.channel_done) begin
				channel_clear_flag <= ev.channel_clear;
			end
		end
	end
endmodule
